// ---- rtl/spa_arbiter.sv ----
`timescale 1ns/1ps
// Operation
// - Once a burst has run for the programmed slot cycles, another requester may break it; a slot of 0 never lets it be broken.
// - Policy 0 disconnects the slave when idle, so the next access costs one cycle.
// - Policy 1 keeps the slave on its last master when idle.
// - Policy 2 parks the slave on the preset owner index when idle.
// - A preset index naming an unconnected master acts as policy 0.
module spa_arbiter #(
   parameter int N = 4,
   parameter int IW = 2,
   parameter logic [7:0] CONN = 8'h0F
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [N-1:0] req,
   input wire logic [N-1:0] burst,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic [N-1:0] grant,
   output logic connected,
   output logic [IW-1:0] owner
);

   // ------------------------------------------------------------
   // Configuration register
   // ------------------------------------------------------------
   spa_pkg::spa_cfg_t cfg_ff, nxt_cfg;
   spa_pkg::spa_req_t bus;
   logic [31:0] rdata_ff, nxt_rdata;
   // Arbitration state is read back through the status word below
   logic conn_ff, nxt_conn;
   logic [IW-1:0] own_ff, nxt_own;
   logic [7:0] slot_cnt_ff, nxt_slot_cnt;

   // Unpack a configuration word; shared by the write port and reset
   function automatic spa_pkg::spa_cfg_t cfg_decode(input logic [31:0] w);
      spa_pkg::spa_cfg_t c;
      c.slot = w[spa_pkg::SLOT_LSB +: spa_pkg::SLOT_W];
      c.policy = w[spa_pkg::POLICY_LSB +: spa_pkg::POLICY_W];
      c.preset = w[spa_pkg::PRESET_LSB +: spa_pkg::PRESET_W];
      c.scheme = w[spa_pkg::SCHEME_LSB +: spa_pkg::SCHEME_W];
      return c;
   endfunction

   // Reset image comes from the same decoder, so the two cannot drift
   localparam spa_pkg::spa_cfg_t CFG_INIT = cfg_decode(spa_pkg::CFG_RESET);

   assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   // Writes store only defined fields; the rest read as zero
   always_comb
   begin
      nxt_cfg = cfg_ff;
      nxt_rdata = '0;
      if (bus.wr && bus.addr == spa_pkg::CFG_OFFSET)
      begin
         nxt_cfg = cfg_decode(bus.wdata);
      end
      if (bus.rd && bus.addr == spa_pkg::CFG_OFFSET)
      begin
         nxt_rdata[spa_pkg::SLOT_LSB +: spa_pkg::SLOT_W] = cfg_ff.slot;
         nxt_rdata[spa_pkg::POLICY_LSB +: spa_pkg::POLICY_W] = cfg_ff.policy;
         nxt_rdata[spa_pkg::PRESET_LSB +: spa_pkg::PRESET_W] = cfg_ff.preset;
         nxt_rdata[spa_pkg::SCHEME_LSB +: spa_pkg::SCHEME_W] = cfg_ff.scheme;
      end
      else if (bus.rd && bus.addr == spa_pkg::STAT_OFFSET)
      begin
         nxt_rdata[7:0] = 8'(slot_cnt_ff);
         nxt_rdata[8] = conn_ff;
         nxt_rdata[16 +: IW] = own_ff;
      end
   end

   // ------------------------------------------------------------
   // Arbitration state
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BUSY = 2'b01
   } spa_state_t;

   spa_state_t st_ff, nxt_st;
   logic [N-1:0] others;
   logic found;
   logic [IW-1:0] win;
   logic preset_ok;

   // Requests from anyone except the current owner
   always_comb
   begin
      others = req;
      others[own_ff] = 1'b0;
   end

   spa_pick #(
      .N(N),
      .IW(IW)
   ) u_pick (
      .req(st_ff == ST_BUSY ? others : req),
      .last(own_ff),
      .scheme(cfg_ff.scheme),
      .found(found),
      .idx(win)
   );

   // Preset index must name a master wired to this slave
   assign preset_ok = (int'(cfg_ff.preset) < N) && CONN[cfg_ff.preset];

   // Next owner: hand over, break burst, or park on idle
   always_comb
   begin
      nxt_st = st_ff;
      nxt_conn = conn_ff;
      nxt_own = own_ff;
      nxt_slot_cnt = slot_cnt_ff;
      case (st_ff)
         ST_IDLE:
         begin
            // A parked owner requesting is served without the extra cycle
            if (conn_ff && req[own_ff])
            begin
               nxt_st = ST_BUSY;
               nxt_slot_cnt = 8'h01;
            end
            else if (found)
            begin
               // Connect first; access proceeds next cycle
               nxt_conn = 1'b1;
               nxt_own = win;
               nxt_slot_cnt = 8'h00;
               nxt_st = ST_BUSY;
            end
         end
         ST_BUSY:
         begin
            if (!req[own_ff])
            begin
               nxt_slot_cnt = 8'h00;
               if (found)
               begin
                  nxt_own = win;
                  nxt_conn = 1'b1;
               end
               else
               begin
                  nxt_st = ST_IDLE;
                  case (cfg_ff.policy)
                     spa_pkg::POLICY_NONE: nxt_conn = 1'b0;
                     spa_pkg::POLICY_LAST: nxt_conn = 1'b1;
                     spa_pkg::POLICY_FIXED:
                     begin
                        nxt_conn = preset_ok;
                        nxt_own = preset_ok ? IW'(cfg_ff.preset) : own_ff;
                     end
                     default: nxt_conn = 1'b0;
                  endcase
               end
            end
            else if (burst[own_ff] && found && cfg_ff.slot != 8'h00
                     && slot_cnt_ff >= cfg_ff.slot)
            begin
               // Slot used up: another requester takes the slave
               nxt_own = win;
               nxt_slot_cnt = 8'h00;
            end
            else if (!burst[own_ff] && found)
            begin
               // Single access done: rotate to a waiting master
               nxt_own = win;
               nxt_slot_cnt = 8'h00;
            end
            else if (slot_cnt_ff != 8'hFF)
               nxt_slot_cnt = slot_cnt_ff + 8'h01;
         end
         default:
            nxt_st = ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // Clock enable freezes everything, including the read port
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cfg_ff <= CFG_INIT;
         rdata_ff <= '0;
         st_ff <= ST_IDLE;
         conn_ff <= 1'b0;
         own_ff <= '0;
         slot_cnt_ff <= '0;
         grant <= '0;
         connected <= 1'b0;
         owner <= '0;
      end
      else if (ce)
      begin
         cfg_ff <= nxt_cfg;
         rdata_ff <= nxt_rdata;
         st_ff <= nxt_st;
         conn_ff <= nxt_conn;
         own_ff <= nxt_own;
         slot_cnt_ff <= nxt_slot_cnt;
         grant <= nxt_conn ? (N'(1) << nxt_own) : '0;
         connected <= nxt_conn;
         owner <= nxt_own;
      end
   end

   assign rdata = rdata_ff;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_idle_disconnect: assert property (
      (ce && st_ff == ST_BUSY && !req[own_ff] && req == '0
       && cfg_ff.policy == spa_pkg::POLICY_NONE) |=> !connected)
      else $error("slave stayed connected under policy 0");

   a_idle_keep_last: assert property (
      (ce && st_ff == ST_BUSY && req == '0
       && cfg_ff.policy == spa_pkg::POLICY_LAST)
      |=> connected && owner == $past(own_ff))
      else $error("slave left last master under policy 1");

   a_idle_park_fixed: assert property (
      (ce && st_ff == ST_BUSY && req == '0 && preset_ok
       && cfg_ff.policy == spa_pkg::POLICY_FIXED)
      |=> connected && owner == IW'($past(cfg_ff.preset)))
      else $error("slave not parked on preset owner");

   a_bad_preset: assert property (
      (ce && st_ff == ST_BUSY && req == '0 && !preset_ok
       && cfg_ff.policy == spa_pkg::POLICY_FIXED) |=> !connected)
      else $error("bad preset did not disconnect");

   a_slot_break: assert property (
      (ce && st_ff == ST_BUSY && req[own_ff] && burst[own_ff] && found
       && cfg_ff.slot != 8'h00 && slot_cnt_ff >= cfg_ff.slot)
      |=> owner != $past(own_ff))
      else $error("burst not broken at slot limit");

   a_no_early_break: assert property (
      (ce && st_ff == ST_BUSY && req[own_ff] && burst[own_ff]
       && slot_cnt_ff < cfg_ff.slot) |=> owner == $past(own_ff))
      else $error("burst broken before slot limit");

   a_prio_lowest: assert property (
      (ce && st_ff == ST_IDLE && !conn_ff && req[0]
       && cfg_ff.scheme == spa_pkg::SCHEME_PRIO) |=> owner == '0)
      else $error("fixed priority did not pick master 0");

   a_grant_onehot: assert property (
      $onehot0(grant) && (connected == (grant != '0)))
      else $error("grant not one-hot with connected");

   a_first_latency: assert property (
      (ce && st_ff == ST_IDLE && !conn_ff && found)
      |=> connected && st_ff == ST_BUSY && slot_cnt_ff == 8'h00)
      else $error("disconnected start lacks connect cycle");

   // Read data stand one cycle only, so a stale word never leaks
   a_rdata_clear: assert property (
      (ce && !rd) |=> rdata == 32'h00000000)
      else $error("read data not cleared after the read cycle");

   // A low clock enable must hold every output where it was
   a_ce_freeze: assert property (
      !ce |=> $stable(grant) && $stable(owner) && $stable(connected)
      && $stable(rdata))
      else $error("outputs moved while clock enable was low");

   a_park_no_wait: assert property (
      (ce && st_ff == ST_IDLE && conn_ff && req[own_ff])
      |=> connected && owner == $past(own_ff))
      else $error("parked owner paid an extra cycle");

   a_single_rotate: assert property (
      (ce && st_ff == ST_BUSY && req[own_ff] && !burst[own_ff] && found)
      |=> owner != $past(own_ff))
      else $error("single access did not rotate to a waiting master");

   // Round-robin must look first at the master just after the last one
   a_rr_next_index: assert property (
      (ce && st_ff == ST_IDLE && !conn_ff
       && cfg_ff.scheme == spa_pkg::SCHEME_RR
       && req[IW'((int'(own_ff) + 1) % N)])
      |=> owner == IW'((int'($past(own_ff)) + 1) % N))
      else $error("round-robin skipped the next master");

   // A lone requester is never taken off the slave
   a_owner_held: assert property (
      (ce && st_ff == ST_BUSY && req == (N'(1) << own_ff))
      |=> connected && owner == $past(own_ff))
      else $error("sole requester lost the slave");

   c_break: cover property (ce && st_ff == ST_BUSY && nxt_own != own_ff
      && req[own_ff]);
   c_park_fixed: cover property (ce && st_ff == ST_BUSY && req == '0
      && cfg_ff.policy == spa_pkg::POLICY_FIXED);
   c_park_last: cover property (ce && st_ff == ST_IDLE && conn_ff
      && req[own_ff]);
   c_rr: cover property (ce && cfg_ff.scheme == spa_pkg::SCHEME_RR
      && $countones(req) > 1);

endmodule // spa_arbiter

// ---- rtl/spa_pkg.sv ----
package spa_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [31:0] CFG_OFFSET = 32'h400E0240;
   localparam logic [31:0] STAT_OFFSET = 32'h400E0244;
   localparam logic [31:0] CFG_RESET = 32'h00000010;

   // ------------------------------------------------------------
   // Field positions of the configuration word
   // ------------------------------------------------------------
   localparam int SLOT_LSB = 0;
   localparam int SLOT_W = 8;
   localparam int POLICY_LSB = 16;
   localparam int POLICY_W = 2;
   localparam int PRESET_LSB = 18;
   localparam int PRESET_W = 3;
   localparam int SCHEME_LSB = 24;
   localparam int SCHEME_W = 2;

   // ------------------------------------------------------------
   // Encodings
   // ------------------------------------------------------------
   localparam logic [1:0] POLICY_NONE = 2'h0;
   localparam logic [1:0] POLICY_LAST = 2'h1;
   localparam logic [1:0] POLICY_FIXED = 2'h2;
   localparam logic [1:0] SCHEME_RR = 2'h0;
   localparam logic [1:0] SCHEME_PRIO = 2'h1;

   // Decoded configuration
   typedef struct packed {
      logic [1:0] scheme;
      logic [2:0] preset;
      logic [1:0] policy;
      logic [7:0] slot;
   } spa_cfg_t;

   // Register port request
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } spa_req_t;

endpackage

// ---- rtl/spa_pick.sv ----
`timescale 1ns/1ps
// Combinational winner selection: round-robin or fixed priority
module spa_pick #(
   parameter int N = 4,
   parameter int IW = 2
) (
   input wire logic [N-1:0] req,
   input wire logic [IW-1:0] last,
   input wire logic [1:0] scheme,
   output logic found,
   output logic [IW-1:0] idx
);

   // ------------------------------------------------------------
   // Search
   // ------------------------------------------------------------
   // Round-robin starts just after the last owner, priority at 0
   always_comb
   begin
      logic [IW-1:0] cand;
      cand = '0;
      found = 1'b0;
      idx = '0;
      for (int k = N - 1; k >= 0; k--)
      begin
         if (scheme == spa_pkg::SCHEME_RR)
            cand = IW'((int'(last) + 1 + k) % N);
         else
            cand = IW'(k);
         if (req[cand])
         begin
            found = 1'b1;
            idx = cand;
         end
      end
   end

endmodule // spa_pick

// ---- verification/spa_master_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bus masters facing the slave port
// ------------------------------------------------------------
module spa_master_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] start,
   input wire logic [3:0] is_burst,
   input wire logic [7:0] hold_len,
   input wire logic [3:0] grant,
   output logic [3:0] req,
   output logic [3:0] burst
);
   logic [7:0] cnt_ff [4];

   // Hold the request until served for hold_len granted cycles
   // A master that loses a broken burst keeps asking, as real ones do
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         req <= 4'h0;
         burst <= 4'h0;
         for (int i = 0; i < 4; i++) cnt_ff[i] <= 8'h00;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (start[i])
            begin
               req[i] <= 1'b1;
               burst[i] <= is_burst[i];
               cnt_ff[i] <= hold_len;
            end
            else if (req[i] && grant[i])
            begin
               cnt_ff[i] <= cnt_ff[i] - 8'h01;
               if (cnt_ff[i] == 8'h01) req[i] <= 1'b0;
            end
         end
      end
   end
endmodule // spa_master_model

// ---- verification/spa_arbiter_tb.sv ----
`timescale 1ns/1ps
module spa_arbiter_tb;
   logic clk, rst, ce, wr, rd, connected;
   logic [31:0] addr, wdata, rdata;
   logic [3:0] req, burst, grant, start, is_burst;
   logic [7:0] hold_len;
   logic [1:0] owner;
   int fails, tests_run, cycles;

   spa_arbiter u_spa_arbiter (.clk(clk), .rst(rst), .ce(ce), .req(req),
      .burst(burst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .grant(grant), .connected(connected), .owner(owner));
   spa_master_model u_spa_master_model (.clk(clk), .rst(rst),
      .start(start), .is_burst(is_burst), .hold_len(hold_len),
      .grant(grant), .req(req), .burst(burst));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [31:0] cfg(input logic [7:0] slot,
      input logic [1:0] pol, input logic [2:0] pre, input logic [1:0] sch);
      return {6'h00, sch, 3'h0, pre, pol, 8'h00, slot};
   endfunction

   task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [31:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("rdata", exp, rdata);
   endtask

   task automatic launch(input logic [3:0] m, input logic [3:0] b,
                         input logic [7:0] h);
      @(posedge clk);
      start <= m;
      is_burst <= b;
      hold_len <= h;
      @(posedge clk);
      start <= 4'h0;
      #1;
   endtask

   task automatic wait_grant(input logic [3:0] exp, input int bound);
      for (int i = 0; i < bound && grant !== exp; i++) @(posedge clk) #1;
      chk("grant", {28'h0, exp}, {28'h0, grant});
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 80 && req !== 4'h0; i++) @(posedge clk) #1;
      chk("req_idle", 32'h0, {28'h0, req});
      repeat (2) @(posedge clk);
      #1;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      rd_reg(spa_pkg::CFG_OFFSET, spa_pkg::CFG_RESET);
      rd_reg(spa_pkg::STAT_OFFSET, 32'h00000000);
      wr_reg(32'h400E0300, 32'hFFFFFFFF);
      rd_reg(32'h400E0300, 32'h00000000);
      rd_reg(spa_pkg::CFG_OFFSET, spa_pkg::CFG_RESET);
      $display("regs done");
   endtask

   // Master 1 does one access, then the parked state is judged
   task automatic t_idle(input logic [1:0] pol, input logic [2:0] pre,
      input logic [3:0] at_rise, input logic [3:0] park);
      logic [1:0] pidx;
      wr_reg(spa_pkg::CFG_OFFSET, cfg(8'h10, pol, pre, 2'h0));
      launch(4'h2, 4'h0, 8'h03);
      chk("grant_at_rise", {28'h0, at_rise}, {28'h0, grant});
      wait_grant(4'h2, 4);
      wait_idle();
      chk("parked", {28'h0, park}, {28'h0, grant});
      chk("connected", {31'h0, |park}, {31'h0, connected});
      // A parked slave must also name its owner in the status word
      if (|park)
      begin
         pidx = park[3] ? 2'h3 : (park[2] ? 2'h2 : (park[1] ? 2'h1 : 2'h0));
         chk("owner", {30'h0, pidx}, {30'h0, owner});
         rd_reg(spa_pkg::STAT_OFFSET, {14'h0, pidx, 7'h00, 1'b1, 8'h00});
      end
      $display("idle policy %0d done", pol);
   endtask

   task automatic t_break();
      wr_reg(spa_pkg::CFG_OFFSET, cfg(8'h04, 2'h0, 3'h0, 2'h0));
      launch(4'h1, 4'h1, 8'h28);
      wait_grant(4'h1, 6);
      launch(4'h4, 4'h0, 8'h02);
      // Second request is seen here, still short of the slot limit
      @(posedge clk) #1;
      chk("grant_early", 32'h1, {28'h0, grant});
      wait_grant(4'h4, 8);
      chk("owner", 32'h2, {30'h0, owner});
      wait_grant(4'h1, 8);
      wait_idle();
      $display("break done");
   endtask

   task automatic t_scheme(input logic [1:0] sch, input logic [3:0] m,
      input logic [3:0] pair, input logic [3:0] exp);
      wr_reg(spa_pkg::CFG_OFFSET, cfg(8'h10, 2'h0, 3'h0, sch));
      launch(m, 4'h0, 8'h02);
      wait_idle();
      launch(pair, 4'h0, 8'h02);
      wait_grant(exp, 6);
      wait_idle();
      $display("scheme %0d done", sch);
   endtask

   // Clock enable low: requests wait until it returns, a register write is dropped
   task automatic t_freeze();
      @(posedge clk);
      ce <= 1'b0;
      launch(4'h2, 4'h0, 8'h02);
      wr_reg(spa_pkg::CFG_OFFSET, cfg(8'h20, 2'h1, 3'h0, 2'h1));
      #1 chk("frozen_grant", 32'h0, {28'h0, grant});
      @(posedge clk);
      ce <= 1'b1;
      wait_grant(4'h2, 4);
      rd_reg(spa_pkg::CFG_OFFSET, cfg(8'h10, 2'h0, 3'h0, 2'h0));
      wait_idle();
      $display("freeze done");
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // 20 ns clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Hang guard well above the expected run length
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         end_of_test();
      end
   end

   initial
   begin
      {rst, ce, wr, rd, start, is_burst} = '0;
      {addr, wdata, hold_len, fails, tests_run, cycles} = '0;
      rst = 1'b1;
      ce = 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_idle(2'h0, 3'h0, 4'h0, 4'h0);
      t_idle(2'h1, 3'h0, 4'h0, 4'h2);
      t_idle(2'h1, 3'h0, 4'h2, 4'h2);
      t_idle(2'h2, 3'h3, 4'h2, 4'h8);
      t_idle(2'h2, 3'h5, 4'h8, 4'h0);
      t_break();
      t_scheme(2'h1, 4'h4, 4'h9, 4'h1);
      t_scheme(2'h0, 4'h2, 4'h5, 4'h4);
      t_freeze();
      end_of_test();
   end
endmodule // spa_arbiter_tb
